// File: common/slpt_pkg.sv
/*
  Constants, field layout and carrier types for the serial link physical
  layer timing registers. Assumes one configuration access port that
  selects a link by its function number and a dword by its offset.
*/
package slpt_pkg;

  // ----------------------------------------------------------------
  // Register offsets, function numbers and link count
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_PLL_STATUS = 8'h50;
  localparam logic [7:0] OFS_PLL_NEXT   = 8'h54;
  localparam logic [7:0] OFS_RETRAIN    = 8'ha4;
  localparam logic [7:0] OFS_STANDBY    = 8'ha8;
  localparam logic [7:0] OFS_EP_SELECT  = 8'he0;
  localparam logic [7:0] OFS_EQ_CTRL    = 8'hf4;
  localparam logic [2:0] FUNC_LINK0     = 3'h1;
  localparam logic [2:0] FUNC_LINK1     = 3'h5;
  localparam int         NUM_LINKS      = 2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int POS_DUR_STEP  = 22;
  localparam int POS_PKT_CNT   = 14;
  localparam int POS_EXPONENT  = 10;
  localparam int POS_BASE      = 0;
  localparam int POS_REM_MIN   = 26;
  localparam int POS_REM_WAKE  = 16;
  localparam int POS_LOC_MIN   = 10;
  localparam int POS_LOC_WAKE  = 0;
  localparam int POS_EP_SEL    = 16;
  localparam int POS_MISC      = 8;
  localparam int POS_EQ_COEF   = 3;
  localparam int POS_EQ_EN     = 2;
  localparam int POS_MAX_RATIO = 24;
  localparam int POS_MIN_RATIO = 16;
  localparam int POS_MASK      = 8;
  localparam int POS_CUR_RATIO = 0;
  localparam int POS_NEXT      = 0;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  EP_SEL_EQ      = 8'h06;
  localparam logic [7:0]  EP_SEL_RST     = 8'h00;
  localparam logic [4:0]  EQ_COEF_RST    = 5'h0c;
  localparam logic        EQ_EN_RST      = 1'b1;
  localparam logic [23:0] MISC_RST       = 24'h000000;
  localparam logic [6:0]  NEXT_RATIO_RST = 7'h0c;

  // ----------------------------------------------------------------
  // Timing in unit intervals, and the ratio unit in MHz
  // ----------------------------------------------------------------
  localparam int         BASE_UI_LOG2   = 10;
  localparam int         FINE_STEP_LOG2 = 4;
  localparam int         COARSE_STEP_LOG2 = 6;
  localparam int         WAKE_STEP_LOG2 = 4;
  localparam logic [6:0] STBY_UI_00     = 7'd32;
  localparam logic [6:0] STBY_UI_01     = 7'd48;
  localparam logic [6:0] STBY_UI_10     = 7'd64;
  localparam logic [6:0] STBY_UI_11     = 7'd96;
  localparam int         RATIO_UNIT_MHZ = 133;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        durStepFine;
    logic [7:0]  retrainPacketCount;
    logic [3:0]  retrainIntervalExponent;
    logic [7:0]  retrainBaseInterval;
    logic [1:0]  remoteMinStandbyCode;
    logic [5:0]  remoteWakeTime;
    logic [1:0]  localMinStandbyCode;
    logic [5:0]  localWakeTime;
    logic [7:0]  elecParamSelectField;
    logic [23:0] miscParamControl;
    logic [4:0]  eqCoef;
    logic        eqEnable;
    logic [6:0]  nextRatio;
  } slpt_link_regs_t;

  typedef struct packed {
    logic       rd;
    logic       wr;
    logic [2:0] func;
    logic [7:0] offset;
    logic [31:0] wrData;
  } slpt_cfg_req_t;

  function automatic logic [6:0] slpt_min_standby_ui(input logic [1:0] code);
    case (code)
      2'b00:   slpt_min_standby_ui = STBY_UI_00;
      2'b01:   slpt_min_standby_ui = STBY_UI_01;
      2'b10:   slpt_min_standby_ui = STBY_UI_10;
      default: slpt_min_standby_ui = STBY_UI_11;
    endcase
  endfunction

endpackage

// File: core/slpt_sync.sv
/*
  Three-stage synchroniser for the forwarded link clock with a
  unit-interval tick on each settled edge. Assumes the link clock is
  well below half the system clock rate.
*/
`timescale 1ns/1ps
module slpt_sync (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // Link clock pin
  input  wire logic linkClk,
  // Unit interval tick
  output logic      uiTick
);
  import slpt_pkg::*;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic tick;
  } slpt_sync_st_t;

  slpt_sync_st_t stateQ;
  slpt_sync_st_t stateD;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    stateD = stateQ;
    stateD.s1 = linkClk;
    stateD.s2 = stateQ.s1;
    stateD.s3 = stateQ.s2;
    // Change accepted only once two late stages agree
    if (stateQ.s2 == stateQ.s3) begin
      stateD.level = stateQ.s3;
    end
    // Both edges count: one unit interval each
    stateD.tick = (stateD.level != stateQ.level);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stateQ <= '0;
    end else begin
      stateQ <= stateD;
    end
  end

  assign uiTick = stateQ.tick;

endmodule // slpt_sync

// File: core/slpt_standby_timer.sv
/*
  Local transmitter standby residency timer for one link. Assumes a
  unit-interval tick from the link clock synchroniser.
*/
`timescale 1ns/1ps
module slpt_standby_timer (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // Timing
  input  wire logic       uiTick,
  input  wire logic [1:0] minCode,
  input  wire logic [5:0] wakeTime,
  // Control
  input  wire logic       standbyReq,
  output logic            standbyActive
);
  import slpt_pkg::*;

  typedef struct packed {
    logic       active;
    logic [6:0] dwell;
  } slpt_stby_st_t;

  slpt_stby_st_t stateQ;
  slpt_stby_st_t stateD;

  always_comb begin
    stateD = stateQ;
    if (!stateQ.active) begin
      // Zero wake field: standby not supported
      if (standbyReq && (wakeTime != 6'h00)) begin
        stateD.active = 1'b1;
        stateD.dwell  = 7'h00;
      end
    end else begin
      if (uiTick && (stateQ.dwell != 7'h7f)) begin
        stateD.dwell = stateQ.dwell + 7'h01;
      end
      // Leave only after the coded minimum residency
      if (!standbyReq && (stateQ.dwell >= slpt_min_standby_ui(minCode))) begin
        stateD.active = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stateQ <= '0;
    end else begin
      stateQ <= stateD;
    end
  end

  assign standbyActive = stateQ.active;

endmodule // slpt_standby_timer

// File: core/slpt_regs.sv
/*
  Physical layer timing and ratio registers for two serial links, with
  the periodic retraining timer of each link. Assumes a single-cycle
  configuration access port on sys_clk and one forwarded clock per link.

  // Overview of operation
  // - Granularity bit set: retrain duration steps of 16 UI; clear: 64 UI.
  // - Effective retrain_base_interval is base times two to the exponent.
  // - Retrain_base_interval counter counts every single UI exactly.
  // - Base interval zero disables periodic retraining.
  // - One base interval count equals 1024 UI before the multiplier.
  // - Remote minimum standby code maps to 32, 48, 64 or 96 UI.
  // - Remote wake time is field plus one times 16 UI.
  // - Local transmitter stays in standby at least the coded minimum time.
  // - Local wake time for remote transmitter is field plus one times 16 UI.
  // - Local wake field zero means standby is not supported.
  // - Equalization controls act only while parameter select equals 6.
  // - Five-bit equalization coefficient resets to 12.
  // - Enable bit, reset one, applies or bypasses custom equalization.
  // - Read-only max and min forwarded clock ratios, units of 133 MHz.
  // - At reset, mask applied to next ratio forms the current ratio.
  // - Next ratio write through either link updates both links and mirror.
  // - Next ratio reads return the accessed link's own copy.
  // - Seven-bit next ratio field resets to 12.
  // - Twenty-four-bit misc parameter control field, reset zero.
  // - Speed indicator one means operational speed, zero slow speed.
*/
`timescale 1ns/1ps
module slpt_regs #(
  parameter logic [6:0] MAX_RATIO  = 7'h18,
  parameter logic [6:0] MIN_RATIO  = 7'h06,
  parameter logic [6:0] RATIO_MASK = 7'h00
) (
  // Clock and reset
  input  wire logic                   sys_clk,
  input  wire logic                   arst_n,
  // Configuration access
  input  wire slpt_pkg::slpt_cfg_req_t cfgReq,
  output logic [31:0]                 cfgRdData,
  output logic                        cfgRdValid,
  // Link side
  input  wire logic [1:0]             linkClk,
  input  wire logic [1:0]             initSpeedOp,
  input  wire logic [1:0]             standbyReq,
  input  wire logic                   ratioAdopt,
  output logic [1:0]                  retrainReq,
  output logic [1:0]                  retrainActive,
  output logic [1:0]                  standbyActive,
  output logic [1:0][10:0]            remoteWakeUi,
  output logic [1:0][6:0]             remoteMinStandbyUi,
  output logic [1:0][10:0]            localWakeUi,
  // Transmitter and clocking
  output logic [1:0]                  txEqApply,
  output logic [1:0][4:0]             txEqCoef,
  output logic [6:0]                  currentFwdClockRatio,
  output logic [6:0]                  mirrorNextRatio
);
  import slpt_pkg::*;

  typedef struct packed {
    slpt_link_regs_t [1:0] regs;
    logic [1:0][33:0]      intervalCnt;
    logic [1:0][13:0]      durationCnt;
    logic [1:0]            retrainReq;
    logic [1:0]            retrainActive;
    logic [1:0][10:0]      remoteWakeUi;
    logic [1:0][6:0]       remoteMinUi;
    logic [1:0][10:0]      localWakeUi;
    logic [1:0]            eqApply;
    logic [1:0][4:0]       eqCoef;
    logic [6:0]            curRatio;
    logic                  ratioLoaded;
    logic [6:0]            mirrorRatio;
    logic [31:0]           rdData;
    logic                  rdValid;
  } slpt_top_st_t;

  localparam slpt_link_regs_t LINK_RST = '{
    durStepFine:             1'b0,
    retrainPacketCount:      8'h00,
    retrainIntervalExponent: 4'h0,
    retrainBaseInterval:     8'h00,
    remoteMinStandbyCode:    2'h0,
    remoteWakeTime:          6'h00,
    localMinStandbyCode:     2'h0,
    localWakeTime:           6'h00,
    elecParamSelectField:    EP_SEL_RST,
    miscParamControl:        MISC_RST,
    eqCoef:                  EQ_COEF_RST,
    eqEnable:                EQ_EN_RST,
    nextRatio:               NEXT_RATIO_RST
  };

  slpt_top_st_t stateQ;
  slpt_top_st_t stateD;
  logic [1:0]   uiTick;
  logic [1:0]   stbyActive;

  // ----------------------------------------------------------------
  // Per-link clock sampling and standby timing
  // ----------------------------------------------------------------
  for (genvar g = 0; g < NUM_LINKS; g++) begin : gLink
    slpt_sync uSync (
      .sys_clk (sys_clk),
      .arst_n  (arst_n),
      .linkClk (linkClk[g]),
      .uiTick  (uiTick[g])
    );
    slpt_standby_timer uStandby (
      .sys_clk       (sys_clk),
      .arst_n        (arst_n),
      .uiTick        (uiTick[g]),
      .minCode       (stateQ.regs[g].localMinStandbyCode),
      .wakeTime      (stateQ.regs[g].localWakeTime),
      .standbyReq    (standbyReq[g]),
      .standbyActive (stbyActive[g])
    );
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic        hit;
    logic        sel;
    logic [33:0] target;
    logic [13:0] duration;
    logic        retrainOn;
    slpt_link_regs_t r;
    hit       = 1'b0;
    sel       = 1'b0;
    target    = '0;
    duration  = '0;
    retrainOn = 1'b0;
    r         = LINK_RST;
    stateD    = stateQ;

    // Link copy chosen by function number
    if (cfgReq.func == FUNC_LINK0) begin
      hit = 1'b1;
      sel = 1'b0;
    end else if (cfgReq.func == FUNC_LINK1) begin
      hit = 1'b1;
      sel = 1'b1;
    end

    // Writes: whole dword, undocumented bits dropped
    if (cfgReq.wr && hit) begin
      case (cfgReq.offset)
        OFS_RETRAIN: begin
          stateD.regs[sel].durStepFine             = cfgReq.wrData[POS_DUR_STEP];
          stateD.regs[sel].retrainPacketCount      = cfgReq.wrData[POS_PKT_CNT +: 8];
          stateD.regs[sel].retrainIntervalExponent = cfgReq.wrData[POS_EXPONENT +: 4];
          stateD.regs[sel].retrainBaseInterval     = cfgReq.wrData[POS_BASE +: 8];
        end
        OFS_STANDBY: begin
          stateD.regs[sel].remoteMinStandbyCode = cfgReq.wrData[POS_REM_MIN +: 2];
          stateD.regs[sel].remoteWakeTime       = cfgReq.wrData[POS_REM_WAKE +: 6];
          stateD.regs[sel].localMinStandbyCode  = cfgReq.wrData[POS_LOC_MIN +: 2];
          stateD.regs[sel].localWakeTime        = cfgReq.wrData[POS_LOC_WAKE +: 6];
        end
        OFS_EP_SELECT: begin
          stateD.regs[sel].elecParamSelectField = cfgReq.wrData[POS_EP_SEL +: 8];
        end
        OFS_EQ_CTRL: begin
          stateD.regs[sel].miscParamControl = cfgReq.wrData[POS_MISC +: 24];
          stateD.regs[sel].eqCoef           = cfgReq.wrData[POS_EQ_COEF +: 5];
          stateD.regs[sel].eqEnable         = cfgReq.wrData[POS_EQ_EN];
        end
        OFS_PLL_NEXT: begin
          // One write reaches both copies and the mirror port
          stateD.regs[0].nextRatio = cfgReq.wrData[POS_NEXT +: 7];
          stateD.regs[1].nextRatio = cfgReq.wrData[POS_NEXT +: 7];
          stateD.mirrorRatio       = cfgReq.wrData[POS_NEXT +: 7];
        end
        default: begin
        end
      endcase
    end

    // Reads: one cycle later, zero for unmapped or foreign functions
    stateD.rdValid = cfgReq.rd;
    stateD.rdData  = 32'h00000000;
    if (cfgReq.rd && hit) begin
      r = stateQ.regs[sel];
      case (cfgReq.offset)
        OFS_RETRAIN: begin
          stateD.rdData[POS_DUR_STEP]      = r.durStepFine;
          stateD.rdData[POS_PKT_CNT +: 8]  = r.retrainPacketCount;
          stateD.rdData[POS_EXPONENT +: 4] = r.retrainIntervalExponent;
          stateD.rdData[POS_BASE +: 8]     = r.retrainBaseInterval;
        end
        OFS_STANDBY: begin
          stateD.rdData[POS_REM_MIN +: 2]  = r.remoteMinStandbyCode;
          stateD.rdData[POS_REM_WAKE +: 6] = r.remoteWakeTime;
          stateD.rdData[POS_LOC_MIN +: 2]  = r.localMinStandbyCode;
          stateD.rdData[POS_LOC_WAKE +: 6] = r.localWakeTime;
        end
        OFS_EP_SELECT: begin
          stateD.rdData[POS_EP_SEL +: 8] = r.elecParamSelectField;
        end
        OFS_EQ_CTRL: begin
          stateD.rdData[POS_MISC +: 24]   = r.miscParamControl;
          stateD.rdData[POS_EQ_COEF +: 5] = r.eqCoef;
          stateD.rdData[POS_EQ_EN]        = r.eqEnable;
        end
        OFS_PLL_STATUS: begin
          stateD.rdData[POS_MAX_RATIO +: 7] = MAX_RATIO;
          stateD.rdData[POS_MIN_RATIO +: 7] = MIN_RATIO;
          stateD.rdData[POS_MASK +: 7]      = RATIO_MASK;
          stateD.rdData[POS_CUR_RATIO +: 7] = stateQ.curRatio;
        end
        OFS_PLL_NEXT: begin
          stateD.rdData[POS_NEXT +: 7] = r.nextRatio;
        end
        default: begin
        end
      endcase
    end

    // Current ratio: masked next ratio, caught after reset release and again on each ratioAdopt
    if (!stateQ.ratioLoaded || ratioAdopt) begin
      stateD.curRatio    = stateQ.regs[0].nextRatio & ~RATIO_MASK;
      stateD.ratioLoaded = 1'b1;
    end

    // Periodic retraining, each link on its own timer, both timers stepped in the same loop every cycle
    for (int i = 0; i < NUM_LINKS; i++) begin
      // Base interval in 1024 UI units scaled by the exponent
      target = 34'(stateQ.regs[i].retrainBaseInterval)
               << (BASE_UI_LOG2 + int'(stateQ.regs[i].retrainIntervalExponent));
      duration = stateQ.regs[i].durStepFine
                 ? (14'(stateQ.regs[i].retrainPacketCount) << FINE_STEP_LOG2)
                 : (14'(stateQ.regs[i].retrainPacketCount) << COARSE_STEP_LOG2);
      // Slow speed or zero base stops the timer; firmware keeps base zero then
      retrainOn = (stateQ.regs[i].retrainBaseInterval != 8'h00)
                  && initSpeedOp[i]
                  && !stbyActive[i];
      stateD.retrainReq[i] = 1'b0;
      if (!retrainOn) begin
        stateD.intervalCnt[i]   = '0;
        stateD.durationCnt[i]   = '0;
        stateD.retrainActive[i] = 1'b0;
      end else if (stateQ.retrainActive[i]) begin
        if (uiTick[i]) begin
          if (stateQ.durationCnt[i] <= 14'h0001) begin
            stateD.retrainActive[i] = 1'b0;
            stateD.durationCnt[i]   = '0;
          end else begin
            stateD.durationCnt[i] = stateQ.durationCnt[i] - 14'h0001;
          end
        end
      end else if (uiTick[i]) begin
        // Counted per UI, never in coarse steps
        if ((stateQ.intervalCnt[i] + 34'h1) >= target) begin
          stateD.intervalCnt[i]   = '0;
          stateD.retrainReq[i]    = 1'b1;
          stateD.retrainActive[i] = (duration != 14'h0000);
          stateD.durationCnt[i]   = duration;
        end else begin
          stateD.intervalCnt[i] = stateQ.intervalCnt[i] + 34'h1;
        end
      end

      // Decoded timing values for the link layer
      stateD.remoteWakeUi[i] = (11'(stateQ.regs[i].remoteWakeTime) + 11'h001)
                               << WAKE_STEP_LOG2;
      stateD.localWakeUi[i]  = (11'(stateQ.regs[i].localWakeTime) + 11'h001)
                               << WAKE_STEP_LOG2;
      stateD.remoteMinUi[i]  = slpt_min_standby_ui(stateQ.regs[i].remoteMinStandbyCode);

      // Equalization only honoured under the matching select code
      stateD.eqApply[i] = (stateQ.regs[i].elecParamSelectField == EP_SEL_EQ)
                          && stateQ.regs[i].eqEnable;
      stateD.eqCoef[i]  = stateQ.regs[i].eqCoef;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      stateQ             <= '0;
      stateQ.regs[0]     <= LINK_RST;
      stateQ.regs[1]     <= LINK_RST;
      stateQ.mirrorRatio <= NEXT_RATIO_RST;
      stateQ.remoteWakeUi <= {2{11'h010}};
      stateQ.localWakeUi  <= {2{11'h010}};
      stateQ.remoteMinUi  <= {2{STBY_UI_00}};
      stateQ.eqCoef       <= {2{EQ_COEF_RST}};
    end else begin
      stateQ <= stateD;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cfgRdData            = stateQ.rdData;
  assign cfgRdValid           = stateQ.rdValid;
  assign retrainReq           = stateQ.retrainReq;
  assign retrainActive        = stateQ.retrainActive;
  assign standbyActive        = stbyActive;
  assign remoteWakeUi         = stateQ.remoteWakeUi;
  assign remoteMinStandbyUi   = stateQ.remoteMinUi;
  assign localWakeUi          = stateQ.localWakeUi;
  assign txEqApply            = stateQ.eqApply;
  assign txEqCoef             = stateQ.eqCoef;
  assign currentFwdClockRatio = stateQ.curRatio;
  assign mirrorNextRatio      = stateQ.mirrorRatio;

endmodule // slpt_regs

// File: verif/slpt_regs_sva.sv
/* Port assertions for slpt_regs.
   Assumes the package constants and a bind onto every instance. */
`timescale 1ns/1ps
module slpt_regs_sva import slpt_pkg::*; (
  // Clock and reset
  input wire logic                    sys_clk,
  input wire logic                    arst_n,
  // Watched ports
  input wire slpt_pkg::slpt_cfg_req_t cfgReq,
  input wire logic                    cfgRdValid,
  input wire logic [1:0]              initSpeedOp,
  input wire logic [1:0]              retrainReq,
  input wire logic [1:0]              standbyActive,
  input wire logic [1:0][10:0]        localWakeUi,
  input wire logic [1:0]              txEqApply,
  input wire logic [6:0]              mirrorNextRatio
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  logic wr0;
  // Registered fields are checked exactly two cycles after the write below
  assign wr0 = cfgReq.wr && cfgReq.func == FUNC_LINK0;

  chk_read_answer: assert property (cfgReq.rd |=> cfgRdValid)
    else $error("read got no answer");
  chk_read_single: assert property (!cfgReq.rd |=> !cfgRdValid)
    else $error("answer without read");
  chk_next_mirror: assert property (cfgReq.wr && cfgReq.offset == OFS_PLL_NEXT
    && (cfgReq.func == FUNC_LINK0 || cfgReq.func == FUNC_LINK1)
    |=> mirrorNextRatio == $past(cfgReq.wrData[6:0])) else $error("mirror ratio stale");
  chk_eq_gate: assert property (wr0 && cfgReq.offset == OFS_EP_SELECT
    && cfgReq.wrData[23:16] != EP_SEL_EQ |-> ##2 !txEqApply[0]) else $error("eq applied");
  chk_wake_calc: assert property (wr0 && cfgReq.offset == OFS_STANDBY |-> ##2
    localWakeUi[0] == {$past(cfgReq.wrData[5:0], 2) + 7'h1, 4'h0}) else $error("wake time");
  chk_no_standby: assert property ($rose(standbyActive[0])
    |-> localWakeUi[0] != 11'h010) else $error("standby while unsupported");
  chk_slow_retrain: assert property (!initSpeedOp[0] && !$past(initSpeedOp[0])
    |-> !retrainReq[0]) else $error("retrain at slow speed");
  chk_retrain_gap: assert property (retrainReq[0] |=> !retrainReq[0] [*8])
    else $error("retrain requests too close");
  chk_standby_min: assert property ($rose(standbyActive[0]) |=> standbyActive[0] [*8])
    else $error("standby left early");
endmodule // slpt_regs_sva

bind slpt_regs slpt_regs_sva chk_u (.sys_clk, .arst_n, .cfgReq, .cfgRdValid, .initSpeedOp,
  .retrainReq, .standbyActive, .localWakeUi, .txEqApply, .mirrorNextRatio);

// File: verif/slpt_far_end.sv
/* Remote link agent: forwarded clock of each link, 320 ns period.
   Assumes the bench opens and closes frames through run. */
`timescale 1ns/1ps
module slpt_far_end (
  // Frame control
  input  wire logic [1:0] run,
  // Forwarded clocks and edge counts
  output logic [1:0]       linkClk,
  output logic [1:0][15:0] edgeCnt
);
  initial begin
    linkClk = 2'h0;
    edgeCnt = '0;
  end
  // Odd start offset keeps edges off the system clock grid
  for (genvar i = 0; i < 2; i++) begin : g_lane
    initial begin
      #(13 + 50 * i);
      forever #160 if (run[i]) begin
        linkClk[i] = ~linkClk[i];
        edgeCnt[i] = edgeCnt[i] + 16'h1;
      end
    end
  end
endmodule // slpt_far_end

// File: verif/slpt_regs_tb.sv
/* Self-checking bench for slpt_regs.
   Assumes the far-end model and the bound checker. */
`timescale 1ns/1ps
module slpt_regs_tb;
  import slpt_pkg::*;
  logic sys_clk, arst_n, ratioAdopt, cfgRdValid, seen1;
  slpt_cfg_req_t cfgReq;
  logic [31:0] cfgRdData;
  logic [1:0] linkClk, initSpeedOp, standbyReq, run, retrainReq, retrainActive, standbyActive;
  logic [1:0] txEqApply;
  logic [1:0][10:0] remoteWakeUi, localWakeUi;
  logic [1:0][6:0] remoteMinStandbyUi;
  logic [1:0][4:0] txEqCoef;
  logic [6:0] currentFwdClockRatio, mirrorNextRatio;
  logic [1:0][15:0] edgeCnt;
  int failCount, compares, cycles, n, e0;

  slpt_regs dut_u (.sys_clk, .arst_n, .cfgReq, .cfgRdData, .cfgRdValid, .linkClk, .initSpeedOp,
    .standbyReq, .ratioAdopt, .retrainReq, .retrainActive, .standbyActive, .remoteWakeUi,
    .remoteMinStandbyUi, .localWakeUi, .txEqApply, .txEqCoef, .currentFwdClockRatio,
    .mirrorNextRatio);
  slpt_far_end far_u (.run, .linkClk, .edgeCnt);

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cycles++;
    if (retrainReq[1]) seen1 = 1'b1;
    if (cycles == 60000) begin
      failCount++;
      testDone();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failCount++;
      $display("Error %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] f, input logic [7:0] o, input logic [31:0] d);
    @(negedge sys_clk);
    cfgReq = '{rd: 1'b0, wr: 1'b1, func: f, offset: o, wrData: d};
    @(negedge sys_clk);
    cfgReq.wr = 1'b0;
  endtask
  task automatic rd(input logic [2:0] f, input logic [7:0] o, input logic [31:0] e);
    @(negedge sys_clk);
    cfgReq = '{rd: 1'b1, wr: 1'b0, func: f, offset: o, wrData: 32'h0};
    @(negedge sys_clk);
    cfgReq.rd = 1'b0;
    chk(32'(cfgRdValid), 32'h1);
    chk(cfgRdData, e);
  endtask
  // Edges of link 0 until cond rises, bounded
  task automatic edgesTill(input int sel, output int d);
    e0 = edgeCnt[0];
    for (n = 0; n < 9500; n++) begin
      @(negedge sys_clk);
      if (sel == 0 ? retrainReq[0] : sel == 1 ? !retrainActive[0] : !standbyActive[0]) break;
    end
    d = edgeCnt[0] - e0;
  endtask

  task automatic testReset;
    rd(FUNC_LINK0, OFS_EQ_CTRL, 32'h00000064);
    rd(FUNC_LINK1, OFS_PLL_NEXT, 32'h0000000c);
    rd(FUNC_LINK0, OFS_PLL_STATUS, 32'h1806000c);
    rd(FUNC_LINK1, OFS_EP_SELECT, 32'h0);
    rd(3'h2, OFS_PLL_NEXT, 32'h0);
    rd(FUNC_LINK0, 8'h58, 32'h0);
  endtask
  task automatic testRatio;
    wr(FUNC_LINK1, OFS_PLL_NEXT, 32'hffffffa0);
    rd(FUNC_LINK0, OFS_PLL_NEXT, 32'h20);
    rd(FUNC_LINK1, OFS_PLL_NEXT, 32'h20);
    chk(32'(mirrorNextRatio), 32'h20);
    chk(32'(currentFwdClockRatio), 32'h0c);
    wr(FUNC_LINK0, OFS_PLL_STATUS, 32'h0);
    @(negedge sys_clk) ratioAdopt = 1'b1;
    @(negedge sys_clk) ratioAdopt = 1'b0;
    chk(32'(currentFwdClockRatio), 32'h20);
    rd(FUNC_LINK0, OFS_PLL_STATUS, 32'h18060020);
  endtask
  task automatic testEqualize;
    wr(FUNC_LINK0, OFS_EQ_CTRL, 32'habcdefab);
    rd(FUNC_LINK0, OFS_EQ_CTRL, 32'habcdefa8);
    wr(FUNC_LINK0, OFS_EP_SELECT, 32'hff06ffff);
    rd(FUNC_LINK0, OFS_EP_SELECT, 32'h00060000);
    chk(32'(txEqApply), 32'h0);
    wr(FUNC_LINK0, OFS_EQ_CTRL, 32'h64);
    rd(FUNC_LINK1, OFS_EP_SELECT, 32'h0);
    chk(32'(txEqApply), 32'h1);
    chk(32'(txEqCoef[0]), 32'd12);
    wr(FUNC_LINK0, OFS_EP_SELECT, 32'h00070000);
    rd(FUNC_LINK0, OFS_EP_SELECT, 32'h00070000);
    chk(32'(txEqApply), 32'h0);
  endtask
  task automatic testStandby;
    int d;
    wr(FUNC_LINK0, OFS_STANDBY, 32'h0c050400);
    run = 2'b01;
    standbyReq = 2'b01;
    repeat (300) @(negedge sys_clk);
    chk(32'(standbyActive), 32'h0);
    chk({localWakeUi[0], remoteWakeUi[0], 3'h0, remoteMinStandbyUi[0]}, 32'h02018060);
    standbyReq = 2'b00;
    wr(FUNC_LINK0, OFS_STANDBY, 32'h0c050403);
    rd(FUNC_LINK0, OFS_STANDBY, 32'h0c050403);
    standbyReq = 2'b01;
    @(negedge sys_clk) standbyReq = 2'b00;
    chk(32'(standbyActive), 32'h1);
    edgesTill(2, d);
    chk(32'(d > 46 && d < 51), 32'h1);
  endtask
  task automatic testRetrain;
    int d;
    initSpeedOp = 2'b11;
    run = 2'b11;
    wr(FUNC_LINK0, OFS_RETRAIN, 32'h00408001);
    edgesTill(0, d);
    chk(32'(d > 1022 && d < 1027), 32'h1);
    edgesTill(1, d);
    chk(32'(d > 30 && d < 34), 32'h1);
    wr(FUNC_LINK0, OFS_RETRAIN, 32'h00004401);
    edgesTill(0, d);
    chk(32'(d > 2046 && d < 2051), 32'h1);
    edgesTill(1, d);
    chk(32'(d > 62 && d < 66), 32'h1);
    chk(32'(seen1), 32'h0);
    initSpeedOp = 2'b00;
    edgesTill(0, d);
    chk(32'(d > 2300), 32'h1);
  endtask

  task automatic testDone;
    $display("Comparisons %0d, mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  initial begin
    {arst_n, ratioAdopt, seen1, initSpeedOp, standbyReq, run} = '0;
    cfgReq = '0;
    repeat (5) @(negedge sys_clk);
    arst_n = 1'b1;
    testReset();
    testRatio();
    testEqualize();
    testStandby();
    testRetrain();
    testDone();
  end
endmodule // slpt_regs_tb
